// file: inc/safety_pkg.sv
`default_nettype none
package safety_pkg;
  localparam logic [10:0] NODE_ID = 11'h001;
  localparam logic [10:0] COB_REQ_BASE = 11'h600;
  localparam logic [10:0] COB_RSP_BASE = 11'h580;
  localparam logic [10:0] REQ_ID = COB_REQ_BASE | NODE_ID;
  localparam logic [10:0] RSP_ID = COB_RSP_BASE | NODE_ID;

  localparam logic [7:0] CMD_WR2 = 8'h2B;
  localparam logic [7:0] CMD_WR_OK = 8'h60;
  localparam logic [7:0] CMD_RD = 8'h40;
  localparam logic [7:0] CMD_RD2_OK = 8'h4B;
  localparam logic [7:0] CMD_RD4_OK = 8'h43;
  localparam logic [7:0] CMD_ABORT = 8'h80;
  localparam logic [31:0] ABORT_BAD_CMD = 32'h05040001;
  localparam logic [31:0] ABORT_RO = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJ = 32'h06020000;
  localparam logic [31:0] ABORT_NO_SUB = 32'h06090011;

  localparam logic [15:0] IDX_CW = 16'h6040;
  localparam logic [15:0] IDX_SW = 16'h6041;
  localparam logic [15:0] IDX_SAFETY = 16'h4000;
  localparam logic [15:0] IDX_DIN = 16'h60FD;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_STATE = 8'h01;
  localparam logic [7:0] SUB_EVENT = 8'h02;
  localparam logic [15:0] SAFETY_ENTRIES = 16'h0002;

  localparam int CW_BIT_ON = 0;
  localparam int CW_BIT_VOLTAGE = 1;
  localparam int CW_BIT_QSTOP = 2;
  localparam int CW_BIT_RESET = 7;
  localparam logic [3:0] CW_ENABLE_OP = 4'hF;
  localparam logic [15:0] CW_DISABLE_VOLTAGE = 16'h0000;
  localparam logic [15:0] CW_RESET_VAL = 16'h0000;

  localparam int SW_BIT_READY = 0;
  localparam int SW_BIT_ON = 1;
  localparam int SW_BIT_OPEN = 2;
  localparam int SW_BIT_DISABLED = 6;
  localparam int SW_BIT_SAFETY = 14;

  localparam int DIN_BIT_CUT1 = 16;
  localparam int DIN_BIT_CUT2 = 17;

  localparam logic [7:0] H_TX_CMD = 8'h00;
  localparam logic [7:0] H_TX_INDEX = 8'h04;
  localparam logic [7:0] H_TX_DATA = 8'h08;
  localparam logic [7:0] H_GO = 8'h0C;
  localparam logic [7:0] H_STATUS = 8'h10;
  localparam logic [7:0] H_RX_HEAD = 8'h14;
  localparam logic [7:0] H_RX_DATA = 8'h18;
  localparam logic [7:0] H_IRQ_STAT = 8'h1C;
  localparam logic [7:0] H_IRQ_MASK = 8'h20;
  localparam int GO_BIT_SEND = 0;
  localparam int GO_BIT_DISABLE = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_REFUSED = 2;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_READY = 2'b01,
    ST_ENABLED = 2'b10,
    ST_SAFETY = 2'b11
  } drive_state_t;

  // byte 0 command, bytes 1-2 index, byte 3 sub-index, bytes 4-7 data, all little endian
  function automatic logic [63:0] build_frame(input logic [7:0] cmd, input logic [15:0] idx,
                                              input logic [7:0] sub, input logic [31:0] data);
    build_frame = {data, sub, idx, cmd};
  endfunction

  function automatic logic is_disable_voltage(input logic [15:0] cw);
    is_disable_voltage = !cw[CW_BIT_VOLTAGE] && !cw[CW_BIT_RESET];
  endfunction
endpackage
`default_nettype wire

// file: inc/sdo_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdo_link_if (
  input wire logic core_clk
);
  logic req_valid;
  logic [10:0] req_id;
  logic [63:0] req_data;
  logic rsp_valid;
  logic [10:0] rsp_id;
  logic [63:0] rsp_data;

  modport master_mp (
    output req_valid,
    output req_id,
    output req_data,
    input rsp_valid,
    input rsp_id,
    input rsp_data
  );

  modport device_mp (
    input req_valid,
    input req_id,
    input req_data,
    output rsp_valid,
    output rsp_id,
    output rsp_data
  );
endinterface
`default_nettype wire

// file: rtl/sdo_frame_parse.sv
`timescale 1ns/1ns
`default_nettype none
module sdo_frame_parse #(
  parameter logic [10:0] MATCH_ID = 11'h000
) (
  input wire logic valid,
  input wire logic [10:0] id,
  input wire logic [63:0] frame,
  output logic hit,
  output logic [7:0] cmd,
  output logic [15:0] idx,
  output logic [7:0] sub,
  output logic [31:0] data
);
  // frames on other identifiers belong to other nodes
  assign hit = valid && (id == MATCH_ID);
  assign cmd = frame[7:0];
  assign idx = frame[23:8];
  assign sub = frame[31:24];
  assign data = frame[63:32];
endmodule
`default_nettype wire

// file: rtl/torque_cutoff_safety_state.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - cutoff enters safety from any state
// - statusword bit 14 shows safety state
// - only disable-voltage command leaves safety
// - disable voltage means bits 1, 7 zero
// - master exit write: 2B, 6040, 00, zero
// - confirm write with 60, echo, zero data
// - requests on 601, answers on 581
// - object 4000h read-only, count 2
// - sub 1 reads safety state
// - sub 2 reads cutoff event occurred
// - torque cutoff or reset sets safety state; cutoff alone sets event flag
// - both inputs high for normal; relays follow
// - cutoff inputs mirrored into digital inputs object
// - no torque while in safety
// - safety stops and blocks motion
module torque_cutoff_safety_state (
  input wire logic core_clk,
  input wire logic rst,
  sdo_link_if.device_mp link,
  input wire logic first_cutoff_input,
  input wire logic second_cutoff_input,
  input wire logic motion_request,
  output logic first_feedback_relay_open,
  output logic second_feedback_relay_open,
  output logic torque_enable,
  output logic motion_run,
  output logic safety_active,
  output logic cutoff_event,
  output logic [15:0] statusword,
  output logic [31:0] digital_inputs_object,
  output safety_pkg::drive_state_t drive_state
);
  import safety_pkg::*;

  drive_state_t state_r;
  drive_state_t state_nxt;
  logic [15:0] cw_r;
  logic [15:0] cw_nxt;
  logic event_r;
  logic [15:0] sw_r;
  logic [15:0] sw_nxt;
  logic torque_r;
  logic motion_r;
  logic relay1_r;
  logic relay2_r;
  logic [31:0] din_r;
  logic rsp_valid_r;
  logic [63:0] rsp_data_r;
  logic [63:0] rsp_nxt;

  wire logic hit;
  wire logic [7:0] p_cmd;
  wire logic [15:0] p_idx;
  wire logic [7:0] p_sub;
  wire logic [31:0] p_data;

  sdo_frame_parse #(
    .MATCH_ID(REQ_ID)
  ) u_parse (
    .valid(link.req_valid),
    .id(link.req_id),
    .frame(link.req_data),
    .hit(hit),
    .cmd(p_cmd),
    .idx(p_idx),
    .sub(p_sub),
    .data(p_data)
  );

  // both channels at 24V are needed to run
  wire logic both_ok = first_cutoff_input && second_cutoff_input;
  wire logic is_cw = (p_idx == IDX_CW) && (p_sub == 8'h00);
  wire logic cw_wr = hit && (p_cmd == CMD_WR2) && is_cw;
  wire logic exit_cmd = cw_wr && is_disable_voltage(p_data[15:0]);
  wire logic in_safety = (state_r == ST_SAFETY);
  wire logic known_obj = (p_idx == IDX_CW) || (p_idx == IDX_SW) ||
                         (p_idx == IDX_SAFETY) || (p_idx == IDX_DIN);
  wire logic sub0 = (p_sub == 8'h00);
  wire logic [15:0] state_word = {15'h0000, in_safety};
  wire logic [15:0] event_word = {15'h0000, event_r};

  assign cw_nxt = cw_wr ? p_data[15:0] : cw_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DISABLED: begin
        if (cw_r[CW_BIT_QSTOP] && cw_r[CW_BIT_VOLTAGE] && !cw_r[CW_BIT_RESET]) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (is_disable_voltage(cw_r)) begin
          state_nxt = ST_DISABLED;
        end else if (cw_r[3:0] == CW_ENABLE_OP) begin
          state_nxt = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (is_disable_voltage(cw_r)) begin
          state_nxt = ST_DISABLED;
        end else if (cw_r[3:0] != CW_ENABLE_OP) begin
          state_nxt = ST_READY;
        end
      end
      ST_SAFETY: begin
        // a held enable controlword would otherwise re-arm the drive right away
        if (exit_cmd && both_ok) begin
          state_nxt = ST_DISABLED;
        end
      end
      default: state_nxt = ST_SAFETY;
    endcase
    if (!both_ok) begin
      state_nxt = ST_SAFETY;
    end
  end

  always_comb begin
    sw_nxt = 16'h0000;
    sw_nxt[SW_BIT_READY] = (state_nxt == ST_READY) || (state_nxt == ST_ENABLED);
    sw_nxt[SW_BIT_ON] = sw_nxt[SW_BIT_READY];
    sw_nxt[SW_BIT_OPEN] = (state_nxt == ST_ENABLED);
    sw_nxt[SW_BIT_DISABLED] = (state_nxt == ST_DISABLED);
    sw_nxt[SW_BIT_SAFETY] = (state_nxt == ST_SAFETY);
  end

  always_comb begin
    rsp_nxt = build_frame(CMD_ABORT, p_idx, p_sub, ABORT_BAD_CMD);
    if (p_cmd == CMD_WR2) begin
      if (is_cw) begin
        rsp_nxt = build_frame(CMD_WR_OK, p_idx, p_sub, 32'h00000000);
      end else if (known_obj) begin
        rsp_nxt = build_frame(CMD_ABORT, p_idx, p_sub, ABORT_RO);
      end else begin
        rsp_nxt = build_frame(CMD_ABORT, p_idx, p_sub, ABORT_NO_OBJ);
      end
    end else if (p_cmd == CMD_RD) begin
      if (p_idx == IDX_SAFETY && p_sub == SUB_COUNT) begin
        rsp_nxt = build_frame(CMD_RD2_OK, p_idx, p_sub, {16'h0000, SAFETY_ENTRIES});
      end else if (p_idx == IDX_SAFETY && p_sub == SUB_STATE) begin
        rsp_nxt = build_frame(CMD_RD2_OK, p_idx, p_sub, {16'h0000, state_word});
      end else if (p_idx == IDX_SAFETY && p_sub == SUB_EVENT) begin
        rsp_nxt = build_frame(CMD_RD2_OK, p_idx, p_sub, {16'h0000, event_word});
      end else if (p_idx == IDX_SW && sub0) begin
        rsp_nxt = build_frame(CMD_RD2_OK, p_idx, p_sub, {16'h0000, sw_r});
      end else if (p_idx == IDX_CW && sub0) begin
        rsp_nxt = build_frame(CMD_RD2_OK, p_idx, p_sub, {16'h0000, cw_r});
      end else if (p_idx == IDX_DIN && sub0) begin
        rsp_nxt = build_frame(CMD_RD4_OK, p_idx, p_sub, din_r);
      end else if (known_obj) begin
        rsp_nxt = build_frame(CMD_ABORT, p_idx, p_sub, ABORT_NO_SUB);
      end else begin
        rsp_nxt = build_frame(CMD_ABORT, p_idx, p_sub, ABORT_NO_OBJ);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_SAFETY;
      cw_r <= CW_RESET_VAL;
    end else begin
      state_r <= state_nxt;
      cw_r <= cw_nxt;
    end
  end

  // sticky until reset: software sees that a cutoff happened even after exit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_r <= 1'b0;
    end else if (!both_ok) begin
      event_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sw_r <= 16'h0000;
      torque_r <= 1'b0;
      motion_r <= 1'b0;
    end else begin
      sw_r <= sw_nxt;
      torque_r <= (state_nxt == ST_ENABLED);
      motion_r <= (state_nxt == ST_ENABLED) && motion_request;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay1_r <= 1'b0;
      relay2_r <= 1'b0;
      din_r <= 32'h00000000;
    end else begin
      relay1_r <= first_cutoff_input;
      relay2_r <= second_cutoff_input;
      din_r <= 32'h00000000;
      din_r[DIN_BIT_CUT1] <= first_cutoff_input;
      din_r[DIN_BIT_CUT2] <= second_cutoff_input;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 64'h0000000000000000;
    end else begin
      rsp_valid_r <= hit;
      if (hit) begin
        rsp_data_r <= rsp_nxt;
      end
    end
  end

  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_id = RSP_ID;
  assign link.rsp_data = rsp_data_r;
  assign first_feedback_relay_open = relay1_r;
  assign second_feedback_relay_open = relay2_r;
  assign torque_enable = torque_r;
  assign motion_run = motion_r;
  assign safety_active = sw_r[SW_BIT_SAFETY];
  assign cutoff_event = event_r;
  assign statusword = sw_r;
  assign digital_inputs_object = din_r;
  assign drive_state = state_r;
endmodule
`default_nettype wire

// file: rtl/sdo_master_end.sv
`timescale 1ns/1ns
`default_nettype none
module sdo_master_end (
  input wire logic core_clk,
  input wire logic rst,
  sdo_link_if.master_mp link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);
  import safety_pkg::*;

  logic [7:0] tx_cmd_r;
  logic [23:0] tx_index_r;
  logic [31:0] tx_data_r;
  logic busy_r;
  logic [31:0] rx_head_r;
  logic [31:0] rx_data_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  logic req_valid_r;
  logic [63:0] req_data_r;

  wire logic hit;
  wire logic [7:0] p_cmd;
  wire logic [15:0] p_idx;
  wire logic [7:0] p_sub;
  wire logic [31:0] p_data;

  sdo_frame_parse #(
    .MATCH_ID(RSP_ID)
  ) u_parse (
    .valid(link.rsp_valid),
    .id(link.rsp_id),
    .frame(link.rsp_data),
    .hit(hit),
    .cmd(p_cmd),
    .idx(p_idx),
    .sub(p_sub),
    .data(p_data)
  );

  wire logic go_wr = wr && (addr == H_GO);
  wire logic go_any = go_wr && (wdata[GO_BIT_SEND] || wdata[GO_BIT_DISABLE]);
  wire logic start = go_any && !busy_r;
  // only one request outstanding: a second answer could not be told apart
  wire logic refused = go_any && busy_r;
  wire logic got_rsp = hit && busy_r;
  wire logic [63:0] dis_frame =
    build_frame(CMD_WR2, IDX_CW, 8'h00, {16'h0000, CW_DISABLE_VOLTAGE});
  wire logic [63:0] user_frame =
    build_frame(tx_cmd_r, tx_index_r[15:0], tx_index_r[23:16], tx_data_r);

  assign irq_set = {refused, got_rsp && (p_cmd == CMD_ABORT), got_rsp};

  always_comb begin
    rd_val = 32'h00000000;
    if (addr == H_TX_CMD) begin
      rd_val = {24'h000000, tx_cmd_r};
    end else if (addr == H_TX_INDEX) begin
      rd_val = {8'h00, tx_index_r};
    end else if (addr == H_TX_DATA) begin
      rd_val = tx_data_r;
    end else if (addr == H_STATUS) begin
      rd_val = {31'h00000000, busy_r};
    end else if (addr == H_RX_HEAD) begin
      rd_val = rx_head_r;
    end else if (addr == H_RX_DATA) begin
      rd_val = rx_data_r;
    end else if (addr == H_IRQ_STAT) begin
      rd_val = {29'h00000000, irq_stat_r};
    end else if (addr == H_IRQ_MASK) begin
      rd_val = {29'h00000000, irq_mask_r};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_cmd_r <= 8'h00;
      tx_index_r <= 24'h000000;
      tx_data_r <= 32'h00000000;
      irq_mask_r <= 3'h0;
      rdata_r <= 32'h00000000;
    end else begin
      if (wr && addr == H_TX_CMD) begin
        tx_cmd_r <= wdata[7:0];
      end
      if (wr && addr == H_TX_INDEX) begin
        tx_index_r <= wdata[23:0];
      end
      if (wr && addr == H_TX_DATA) begin
        tx_data_r <= wdata;
      end
      if (wr && addr == H_IRQ_MASK) begin
        irq_mask_r <= wdata[IRQ_W-1:0];
      end
      rdata_r <= rd ? rd_val : 32'h00000000;
    end
  end

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat_r <= 3'h0;
    end else if (wr && addr == H_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      req_valid_r <= 1'b0;
      req_data_r <= 64'h0000000000000000;
      rx_head_r <= 32'h00000000;
      rx_data_r <= 32'h00000000;
    end else begin
      req_valid_r <= start;
      if (start) begin
        busy_r <= 1'b1;
        req_data_r <= wdata[GO_BIT_DISABLE] ? dis_frame : user_frame;
      end else if (got_rsp) begin
        busy_r <= 1'b0;
      end
      if (got_rsp) begin
        rx_head_r <= {p_sub, p_idx, p_cmd};
        rx_data_r <= p_data;
      end
    end
  end

  assign link.req_valid = req_valid_r;
  assign link.req_id = REQ_ID;
  assign link.req_data = req_data_r;
  assign rdata = rdata_r;
  assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

// file: test/torque_cutoff_safety_state_properties.sv
`timescale 1ns/1ns
`default_nettype none
module torque_cutoff_safety_state_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [10:0] req_id,
  input wire logic [63:0] req_data,
  input wire logic rsp_valid,
  input wire logic [10:0] rsp_id,
  input wire logic [63:0] rsp_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic to_dev;
  assign to_dev = req_valid && req_id == 11'h601;

  chk_req_id_node: assert property (req_valid |-> req_id == 11'h601)
    else $error("request sent on wrong identifier");
  chk_rsp_id_node: assert property (rsp_valid |-> rsp_id == 11'h581)
    else $error("answer sent on wrong identifier");
  chk_rsp_next_cycle: assert property (to_dev |=> rsp_valid)
    else $error("no answer one cycle after request");
  chk_rsp_has_cause: assert property (rsp_valid |-> $past(to_dev))
    else $error("answer without request");
  chk_cw_echo: assert property (to_dev && req_data[31:0] == 32'h0060402B
    |=> rsp_data == 64'h0000000000604060)
    else $error("controlword write not confirmed with echo");
  chk_exit_frame: assert property (req_valid && req_data[23:0] == 24'h60402B
    |-> req_data[31:24] == 8'h00)
    else $error("controlword write with nonzero sub-index");
  chk_count_read: assert property (to_dev && req_data[31:0] == 32'h00400040
    |=> rsp_data == 64'h000000020040004B)
    else $error("entry count read wrong");
  chk_ro_abort: assert property (to_dev && req_data[23:0] == 24'h40002B
    |=> rsp_data[7:0] == 8'h80 && rsp_data[63:32] == 32'h06010002)
    else $error("write to read-only object not aborted");
  chk_flag_range: assert property (to_dev && req_data[23:0] == 24'h400040
    && (req_data[31:24] == 8'h01 || req_data[31:24] == 8'h02)
    |=> rsp_data[7:0] == 8'h4B && rsp_data[63:33] == 31'h0)
    else $error("safety flag read outside 0 or 1");
  chk_req_pulse: assert property (req_valid |=> !req_valid)
    else $error("request strobe longer than one cycle");
endmodule
`default_nettype wire

// file: test/test_torque_cutoff_safety_state.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module test_torque_cutoff_safety_state;
  import safety_pkg::*;
  logic core_clk = 1'h0;
  logic rst, cut1, cut2, motion_request, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, head, dat;
  logic relay1, relay2, torque_enable, motion_run, safety_active, cutoff_event, irq;
  logic [15:0] statusword;
  logic [31:0] din;
  drive_state_t drive_state;
  int n_mismatch = 0;
  int check_count = 0;

  always #10 core_clk = ~core_clk;

  sdo_link_if link (.core_clk(core_clk));
  torque_cutoff_safety_state i_torque_cutoff_safety_state (.core_clk(core_clk), .rst(rst),
    .link(link), .first_cutoff_input(cut1), .second_cutoff_input(cut2),
    .motion_request(motion_request), .first_feedback_relay_open(relay1),
    .second_feedback_relay_open(relay2), .torque_enable(torque_enable),
    .motion_run(motion_run), .safety_active(safety_active), .cutoff_event(cutoff_event),
    .statusword(statusword), .digital_inputs_object(din), .drive_state(drive_state));
  sdo_master_end i_sdo_master_end (.core_clk(core_clk), .rst(rst), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  torque_cutoff_safety_state_properties i_props (.core_clk(core_clk), .rst(rst),
    .req_valid(link.req_valid), .req_id(link.req_id), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_id(link.rsp_id), .rsp_data(link.rsp_data));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask

  task automatic wait_rsp();
    int i;
    for (i = 0; i < 20 && link.rsp_valid !== 1'h1; i++) @(negedge core_clk);
    if (i == 20) begin
      n_mismatch++;
      $display("ERROR %0t: no answer on link", $time);
      give_verdict();
    end
  endtask

  // one frame through the master registers, answer left in head and dat
  task automatic send(input logic [7:0] c, input logic [15:0] x, input logic [7:0] s,
                      input logic [31:0] d);
    wr_reg(H_TX_CMD, {24'h0, c});
    wr_reg(H_TX_INDEX, {8'h00, s, x});
    wr_reg(H_TX_DATA, d);
    wr_reg(H_GO, 32'h1);
    wait_rsp();
    rd_reg(H_RX_HEAD, head);
    rd_reg(H_RX_DATA, dat);
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1 `CHECK(drive_state, ST_SAFETY)
    `CHECK(torque_enable, 1'h0)
    `CHECK({relay1, relay2}, 2'h3)
    `CHECK(din, 32'h00030000)
  endtask

  task automatic t_exit();
    wr_reg(H_IRQ_MASK, 32'h7);
    wr_reg(H_GO, 32'h2);
    wait_rsp();
    @(posedge core_clk);
    #1 `CHECK(irq, 1'h1)
    rd_reg(H_RX_HEAD, head);
    `CHECK(head, 32'h00604060)
    rd_reg(H_RX_DATA, dat);
    `CHECK(dat, 32'h0)
    `CHECK(drive_state, ST_DISABLED)
    `CHECK(statusword[14], 1'h0)
    `CHECK(safety_active, 1'h0)
    wr_reg(H_IRQ_STAT, 32'h1);
    #1 `CHECK(irq, 1'h0)
  endtask

  task automatic t_run();
    send(CMD_WR2, IDX_CW, 8'h00, 32'h6);
    send(CMD_WR2, IDX_CW, 8'h00, 32'hF);
    @(posedge core_clk);
    motion_request <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1 `CHECK(drive_state, ST_ENABLED)
    `CHECK({torque_enable, motion_run}, 2'h3)
    `CHECK(cutoff_event, 1'h0)
  endtask

  task automatic t_cutoff();
    // drop one channel while running: must fall into safety at once
    @(posedge core_clk);
    cut1 <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1 `CHECK(drive_state, ST_SAFETY)
    `CHECK({safety_active, statusword[14]}, 2'h3)
    `CHECK({torque_enable, motion_run}, 2'h0)
    `CHECK({relay1, relay2}, 2'h1)
    `CHECK(din, 32'h00020000)
    `CHECK(cutoff_event, 1'h1)
    send(CMD_RD, IDX_SAFETY, SUB_EVENT, 32'h0);
    `CHECK(dat, 32'h1)
    send(CMD_RD, IDX_SAFETY, SUB_STATE, 32'h0);
    `CHECK(dat, 32'h1)
  endtask

  task automatic t_refuse_exit();
    send(CMD_WR2, IDX_CW, 8'h00, 32'h0);
    `CHECK(head, 32'h00604060)
    `CHECK(drive_state, ST_SAFETY)
    @(posedge core_clk);
    cut1 <= 1'h1;
    send(CMD_WR2, IDX_CW, 8'h00, 32'h80);
    `CHECK(drive_state, ST_SAFETY)
    send(CMD_WR2, IDX_CW, 8'h00, 32'h4);
    `CHECK(drive_state, ST_DISABLED)
    send(CMD_RD, IDX_SAFETY, SUB_STATE, 32'h0);
    `CHECK(dat, 32'h0)
    send(CMD_RD, IDX_SAFETY, SUB_EVENT, 32'h0);
    `CHECK(dat, 32'h1)
  endtask

  task automatic t_objects();
    send(CMD_RD, IDX_SAFETY, SUB_COUNT, 32'h0);
    `CHECK({head, dat}, 64'h0040004B_00000002)
    send(CMD_WR2, IDX_SAFETY, SUB_STATE, 32'h0);
    `CHECK({head[7:0], dat}, 40'h80_06010002)
    rd_reg(H_IRQ_STAT, dat);
    `CHECK(dat[IRQ_ABORT], 1'h1)
    send(CMD_RD, IDX_DIN, 8'h00, 32'h0);
    `CHECK(dat, 32'h00030000)
    rd_reg(8'h24, dat);
    `CHECK(dat, 32'h0)
  endtask

  task automatic t_irq();
    // masked answer plus a refused second go on the very next edge
    wr_reg(H_IRQ_MASK, 32'h0);
    // earlier answers and aborts left status bits set
    wr_reg(H_IRQ_STAT, 32'h7);
    @(posedge core_clk);
    addr <= H_GO;
    wdata <= 32'h1;
    wr <= 1'h1;
    @(posedge core_clk);
    @(posedge core_clk);
    wr <= 1'h0;
    wait_rsp();
    repeat (2) @(posedge core_clk);
    #1 `CHECK(irq, 1'h0)
    rd_reg(H_IRQ_STAT, dat);
    `CHECK(dat, 32'h5)
    wr_reg(H_IRQ_MASK, 32'h4);
    #1 `CHECK(irq, 1'h1)
    wr_reg(H_IRQ_STAT, 32'h7);
    #1 `CHECK(irq, 1'h0)
  endtask

  task automatic t_rereset();
    // reset in mid-run clears the sticky event and parks the drive in safety
    @(posedge core_clk);
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    #1 `CHECK(drive_state, ST_SAFETY)
    `CHECK(safety_active, 1'h1)
    `CHECK(cutoff_event, 1'h0)
    `CHECK(irq, 1'h0)
  endtask

  initial begin
    rst = 1'h1;
    cut1 = 1'h1;
    cut2 = 1'h1;
    motion_request = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_exit();
    t_run();
    t_cutoff();
    t_refuse_exit();
    t_objects();
    t_irq();
    t_rereset();
    give_verdict();
  end
endmodule
`default_nettype wire
